// *** rtl/bspi_pkg.sv ***
// ----------------------------------------------------------------
// Shared constants for the burst SRAM split-port link
// ----------------------------------------------------------------
package bspi_pkg;

  // Clocking: core clock and the link clock made by the controller
  localparam int CORE_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_DIV       = LINK_PERIOD_NS / CORE_PERIOD_NS;
  localparam int LINK_HALF      = LINK_DIV / 2;

  // Controller phase points within one link period
  localparam logic [2:0] PH_RDY   = 3'h5;  // Raise ready one cycle before the update
  localparam logic [2:0] PH_UPD_K = 3'h6;  // Update outputs for the next primary rise
  localparam logic [2:0] PH_UPD_N = 3'h2;  // Update outputs for the next complement rise

  // Burst and read latency, counted in half link cycles
  localparam int BURST_LEN   = 4;
  localparam int LAT_HALF_HI = 5;  // 2.5 link cycles
  localparam int LAT_HALF_LO = 2;  // 1 link cycle
  localparam int LAT_STAGES  = LAT_HALF_HI;

  // Echo clock delay behind the data launch, in core cycles
  localparam int ECHO_DELAY = 2;

  // Read response buffer
  localparam int RSP_FIFO_DEPTH = 32;

  // Address slot on the shared bus, one-hot
  typedef enum logic [1:0] {
    BSPI_SLOT_RD = 2'b01,
    BSPI_SLOT_WR = 2'b10
  } bspi_slot_e;

endpackage

// *** rtl/bspi_link_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link between the memory device and its controller
// ----------------------------------------------------------------
interface bspi_link_if #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 6
);
  logic              k;
  logic              k_n;
  logic [ADDR_W-1:0] addr;
  logic              rd_sel_n;
  logic              wr_sel_n;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              read_valid_flag;
  logic              echo_clock;
  logic              echo_clock_n;
  logic              latency_select_pin;

  modport dev (
    input  k, k_n, addr, rd_sel_n, wr_sel_n, wr_data, latency_select_pin,
    output rd_data, read_valid_flag, echo_clock, echo_clock_n
  );

  modport ctl (
    output k, k_n, addr, rd_sel_n, wr_sel_n, wr_data, latency_select_pin,
    input  rd_data, read_valid_flag, echo_clock, echo_clock_n
  );
endinterface

// *** rtl/bspi_dev.sv ***
`timescale 1ns/1ps
// Functional notes
// - Each address holds four words, 18 or 36 bits
// - Read and write addresses alternate on primary rises
// - One shared address bus for both ports
// - Data moves on both clock rises
// - Only rising edges of either input clock count
// - Latency pin high: read data after 2.5 cycles
// - Latency pin low: read data after 1 cycle
// - All synchronous inputs registered before use
// - Data outputs launched from output registers
// - Array write completes internally, self-timed
// - Read and write ports run concurrently
// - Valid flag marks read burst data
// - Echo clock pair lags read data to rise mid-word
// - Independent select for each port
// - Reads return the newest written data
module bspi_dev
  import bspi_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 6
) (
  input wire logic core_clk,
  input wire logic arst_n,
  bspi_link_if.dev link
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // word width check
  if (DATA_W != 18 && DATA_W != 36) begin : g_bad_width
    $error("bspi_dev: DATA_W must be 18 or 36");
  end
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
    $error("bspi_dev: ADDR_W out of range");
  end

  localparam int IN_W   = 5 + ADDR_W + DATA_W;
  localparam int WORD_W = $clog2(BURST_LEN);
  localparam int MEM_W  = ADDR_W + WORD_W;

  // Idle levels of the link inputs; k_n idles high, so a zero reset
  // here would fake a complement rise right after release
  localparam logic [IN_W-1:0] IN_IDLE = {2'b01, 1'b0, 2'b11, {(ADDR_W+DATA_W){1'b0}}};

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  // All link inputs cross from the controller through two flops; the
  // clocks ride in the same vector so data and edges stay aligned.
  logic [IN_W-1:0] sync1_q;
  logic [IN_W-1:0] sync2_q;
  logic            k_prev_q;
  logic            kn_prev_q;

  wire [IN_W-1:0] in_vec = {link.k, link.k_n, link.latency_select_pin,
                            link.rd_sel_n, link.wr_sel_n, link.addr, link.wr_data};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= IN_IDLE;
      sync2_q <= IN_IDLE;
    end else begin
      sync1_q <= in_vec;
      sync2_q <= sync1_q;
    end
  end

  wire              k_s        = sync2_q[IN_W-1];
  wire              kn_s       = sync2_q[IN_W-2];
  wire              lat_hi_s   = sync2_q[IN_W-3];
  wire              rd_sel_n_s = sync2_q[IN_W-4];
  wire              wr_sel_n_s = sync2_q[IN_W-5];
  wire [ADDR_W-1:0] addr_s     = sync2_q[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] wdata_s    = sync2_q[DATA_W-1:0];

  // Previous clock levels for edge finding
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      k_prev_q  <= 1'b0;
      kn_prev_q <= 1'b1;
    end else begin
      k_prev_q  <= k_s;
      kn_prev_q <= kn_s;
    end
  end

  wire k_rise  = k_s & ~k_prev_q;
  wire kn_rise = kn_s & ~kn_prev_q;
  wire ev      = k_rise | kn_rise;

  // ----------------------------------------------------------------
  // Address slot sequencing
  // ----------------------------------------------------------------
  // Slot alternates on each primary rise; reset aligns both ends on a
  // read slot first, so a common reset is assumed.
  bspi_slot_e slot_q;
  bspi_slot_e slot_d;

  always_comb begin
    slot_d = slot_q;
    case (slot_q)
      BSPI_SLOT_RD: if (k_rise) slot_d = BSPI_SLOT_WR;
      BSPI_SLOT_WR: if (k_rise) slot_d = BSPI_SLOT_RD;
      default:      slot_d = BSPI_SLOT_RD;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) slot_q <= BSPI_SLOT_RD;
    else         slot_q <= slot_d;
  end

  // one bus, slot picks the port
  wire rd_cap = k_rise & (slot_q == BSPI_SLOT_RD) & ~rd_sel_n_s;
  wire wr_cap = k_rise & (slot_q == BSPI_SLOT_WR) & ~wr_sel_n_s;

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  logic              wr_act_q;
  logic [WORD_W-1:0] wr_idx_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] mem [0:(1<<MEM_W)-1];

  wire             mem_we = wr_cap | (ev & wr_act_q);
  wire [MEM_W-1:0] mem_wa = wr_cap ? {addr_s, {WORD_W{1'b0}}} : {wr_addr_q, wr_idx_q};

  // First word arrives with the address, three more on following rises
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_act_q  <= 1'b0;
      wr_idx_q  <= '0;
      wr_addr_q <= '0;
    end else if (wr_cap) begin
      wr_act_q  <= 1'b1;
      wr_idx_q  <= WORD_W'(1);
      wr_addr_q <= addr_s;
    end else if (ev && wr_act_q) begin
      wr_idx_q  <= wr_idx_q + WORD_W'(1);
      wr_act_q  <= (wr_idx_q != WORD_W'(BURST_LEN - 1));
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (mem_we) mem[mem_wa] <= wdata_s;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // read path separate from write
  logic [LAT_STAGES-1:0] dl_v_q;
  logic [ADDR_W-1:0]     dl_a_q [0:LAT_STAGES-1];

  // Delay line steps once per clock rise and carries captured reads
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dl_v_q[0] <= 1'b0;
      dl_a_q[0] <= '0;
    end else if (ev) begin
      dl_v_q[0] <= rd_cap;
      dl_a_q[0] <= addr_s;
    end
  end

  for (genvar i = 1; i < LAT_STAGES; i++) begin : g_dl
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        dl_v_q[i] <= 1'b0;
        dl_a_q[i] <= '0;
      end else if (ev) begin
        dl_v_q[i] <= dl_v_q[i-1];
        dl_a_q[i] <= dl_a_q[i-1];
      end
    end
  end

  wire [2:0]        tap     = lat_hi_s ? 3'(LAT_HALF_HI - 1) : 3'(LAT_HALF_LO - 1);
  wire              tap_hit = ev & dl_v_q[tap];
  wire [ADDR_W-1:0] tap_a   = dl_a_q[tap];

  logic              rb_act_q;
  logic [WORD_W-1:0] rb_idx_q;
  logic [ADDR_W-1:0] rb_addr_q;
  logic [DATA_W-1:0] rd_data_q;
  logic              rd_valid_q;

  // read the array at launch time
  // Earlier writes always finish each word before it is read back, so
  // no stale data leaves; a write captured after the read may be seen.
  wire [MEM_W-1:0] mem_ra = tap_hit ? {tap_a, {WORD_W{1'b0}}} : {rb_addr_q, rb_idx_q};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_act_q   <= 1'b0;
      rb_idx_q   <= '0;
      rb_addr_q  <= '0;
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end else if (tap_hit) begin
      rb_act_q   <= 1'b1;
      rb_idx_q   <= WORD_W'(1);
      rb_addr_q  <= tap_a;
      rd_data_q  <= mem[mem_ra];
      rd_valid_q <= 1'b1;
    end else if (ev && rb_act_q) begin
      rb_idx_q   <= rb_idx_q + WORD_W'(1);
      rb_act_q   <= (rb_idx_q != WORD_W'(BURST_LEN - 1));
      rd_data_q  <= mem[mem_ra];
    end else if (ev) begin
      rd_valid_q <= 1'b0;  // Data holds; only the flag drops
    end
  end

  // ----------------------------------------------------------------
  // Echo clocks
  // ----------------------------------------------------------------
  // Echo follows the input clocks but lags the data launch so that its
  // rise lands mid-word at the controller, giving it capture margin.
  logic [ECHO_DELAY-1:0] echo_k_q;
  logic [ECHO_DELAY-1:0] echo_kn_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      echo_k_q  <= '0;
      echo_kn_q <= '1;
    end else begin
      echo_k_q  <= {echo_k_q[ECHO_DELAY-2:0], k_prev_q};
      echo_kn_q <= {echo_kn_q[ECHO_DELAY-2:0], kn_prev_q};
    end
  end

  assign link.rd_data         = rd_data_q;
  assign link.read_valid_flag = rd_valid_q;
  assign link.echo_clock      = echo_k_q[ECHO_DELAY-1];
  assign link.echo_clock_n    = echo_kn_q[ECHO_DELAY-1];

endmodule

// *** rtl/bspi_ctl.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Read response FIFO with registered output
// ----------------------------------------------------------------
module bspi_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic                     in_valid,
  output wire logic                     in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output wire logic                     out_valid,
  input  wire logic                     out_ready,
  output wire logic [WIDTH-1:0]         out_data,
  output wire logic [$clog2(DEPTH):0]   level
);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("bspi_fifo: DEPTH must be a power of two");
  end

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW:0]      wp_q;
  logic [PW:0]      rp_q;
  logic             ov_q;
  logic [WIDTH-1:0] od_q;

  wire empty = (wp_q == rp_q);
  wire full  = (wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]);
  wire push  = in_valid & ~full;
  wire pop   = ~empty & (~ov_q | out_ready);

  // Pointers and the output stage; the drain side stalls the pop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + (PW+1)'(1);
      if (pop) begin
        rp_q <= rp_q + (PW+1)'(1);
        od_q <= mem[rp_q[PW-1:0]];
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wp_q[PW-1:0]] <= in_data;
  end

  assign in_ready  = ~full;
  assign out_valid = ov_q;
  assign out_data  = od_q;
  assign level     = wp_q - rp_q;
endmodule

// ----------------------------------------------------------------
// Memory controller end of the link
// ----------------------------------------------------------------
module bspi_ctl
  import bspi_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 6,
  parameter int DEPTH  = RSP_FIFO_DEPTH
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  bspi_link_if.ctl                           link,
  input  wire logic                          latency_select,
  input  wire logic                          wr_valid,
  output wire logic                          wr_ready,
  input  wire logic [ADDR_W-1:0]             wr_addr,
  input  wire logic [BURST_LEN*DATA_W-1:0]   wr_data,
  input  wire logic                          rd_valid,
  output wire logic                          rd_ready,
  input  wire logic [ADDR_W-1:0]             rd_addr,
  output wire logic                          rsp_valid,
  input  wire logic                          rsp_ready,
  output wire logic [DATA_W-1:0]             rsp_data
);
  if (DEPTH < BURST_LEN) begin : g_bad_depth
    $error("bspi_ctl: DEPTH must hold one burst");
  end

  localparam int CW     = $clog2(DEPTH) + 1;
  localparam int WORD_W = $clog2(BURST_LEN);

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  logic [2:0] ph_q;
  logic       k_q;
  logic       kn_q;

  // Link clock made from the core clock; complement is its inverse
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= 3'h0;
      k_q  <= 1'b0;
      kn_q <= 1'b1;
    end else begin
      ph_q <= (ph_q == 3'(LINK_DIV - 1)) ? 3'h0 : ph_q + 3'h1;
      k_q  <= (ph_q < 3'(LINK_HALF));
      kn_q <= ~(ph_q < 3'(LINK_HALF));
    end
  end

  // ----------------------------------------------------------------
  // Request issue
  // ----------------------------------------------------------------
  bspi_slot_e                slot_q;
  logic                      rd_rdy_q;
  logic                      wr_rdy_q;
  logic [ADDR_W-1:0]         addr_q;
  logic                      rd_sel_n_q;
  logic                      wr_sel_n_q;
  logic [DATA_W-1:0]         wd_q;
  logic [BURST_LEN*DATA_W-1:0] wbuf_q;
  logic                      wb_act_q;
  logic [WORD_W-1:0]         wb_idx_q;
  logic [CW-1:0]             infl_q;
  logic                      lat_q;
  logic [CW-1:0]             level;
  logic                      fifo_in_ready;

  wire upd_k = (ph_q == PH_UPD_K);
  wire upd_n = (ph_q == PH_UPD_N);
  wire rtake = upd_k & (slot_q == BSPI_SLOT_RD) & rd_rdy_q & rd_valid;
  wire wtake = upd_k & (slot_q == BSPI_SLOT_WR) & wr_rdy_q & wr_valid;
  wire [DATA_W-1:0] wr_word = wbuf_q[wb_idx_q*DATA_W +: DATA_W];

  // Read is offered only when the buffer can absorb the whole burst
  wire [CW:0] need    = {1'b0, level} + {1'b0, infl_q} + (CW+1)'(BURST_LEN);
  wire        credit  = (need <= (CW+1)'(DEPTH)) & fifo_in_ready;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_q   <= BSPI_SLOT_WR;  // Rise one passes unused; first update feeds a write slot
      rd_rdy_q <= 1'b0;
      wr_rdy_q <= 1'b0;
      lat_q    <= 1'b0;
    end else begin
      if (upd_k) slot_q <= (slot_q == BSPI_SLOT_RD) ? BSPI_SLOT_WR : BSPI_SLOT_RD;
      rd_rdy_q <= (ph_q == PH_RDY) & (slot_q == BSPI_SLOT_RD) & credit;
      wr_rdy_q <= (ph_q == PH_RDY) & (slot_q == BSPI_SLOT_WR);
      lat_q    <= latency_select;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q     <= '0;
      rd_sel_n_q <= 1'b1;
      wr_sel_n_q <= 1'b1;
    end else if (upd_k) begin
      rd_sel_n_q <= ~rtake;
      wr_sel_n_q <= ~wtake;
      if (rtake) addr_q <= rd_addr;
      if (wtake) addr_q <= wr_addr;
    end
  end

  // one write word per clock rise
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_q     <= '0;
      wbuf_q   <= '0;
      wb_act_q <= 1'b0;
      wb_idx_q <= '0;
    end else if (wtake) begin
      wbuf_q   <= wr_data;
      wd_q     <= wr_data[DATA_W-1:0];
      wb_act_q <= 1'b1;
      wb_idx_q <= WORD_W'(1);
    end else if ((upd_k || upd_n) && wb_act_q) begin
      wd_q     <= wr_word;
      wb_idx_q <= wb_idx_q + WORD_W'(1);
      wb_act_q <= (wb_idx_q != WORD_W'(BURST_LEN - 1));
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  localparam int RW = DATA_W + 3;

  // Idle levels of the device outputs; the inverse echo idles high,
  // so a zero reset here would fake an echo edge after release
  localparam logic [RW-1:0] RS_IDLE = {1'b0, 1'b1, {(DATA_W+1){1'b0}}};

  logic [RW-1:0] rs1_q;
  logic [RW-1:0] rs2_q;
  logic          ep_q;
  logic          enp_q;

  // Device outputs cross through two flops before any use
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_q <= RS_IDLE;
      rs2_q <= RS_IDLE;
      ep_q  <= 1'b0;
      enp_q <= 1'b1;
    end else begin
      rs1_q <= {link.echo_clock, link.echo_clock_n, link.read_valid_flag, link.rd_data};
      rs2_q <= rs1_q;
      ep_q  <= rs2_q[RW-1];
      enp_q <= rs2_q[RW-2];
    end
  end

  wire echo_edge = (rs2_q[RW-1] & ~ep_q) | (rs2_q[RW-2] & ~enp_q);
  wire cap       = echo_edge & rs2_q[DATA_W];

  // Words promised but not yet captured
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) infl_q <= '0;
    else         infl_q <= infl_q + (rtake ? CW'(BURST_LEN) : CW'(0)) - (cap ? CW'(1) : CW'(0));
  end

  bspi_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_rsp_fifo (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (cap),
    .in_ready  (fifo_in_ready),
    .in_data   (rs2_q[DATA_W-1:0]),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data),
    .level     (level)
  );

  assign link.k                  = k_q;
  assign link.k_n                = kn_q;
  assign link.addr               = addr_q;
  assign link.rd_sel_n           = rd_sel_n_q;
  assign link.wr_sel_n           = wr_sel_n_q;
  assign link.wr_data            = wd_q;
  assign link.latency_select_pin = lat_q;
  assign rd_ready                = rd_rdy_q;
  assign wr_ready                = wr_rdy_q;

endmodule

// *** tb/bspi_link_monitor.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link checker beside the shared interface
// ----------------------------------------------------------------
module bspi_link_monitor #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 6
) (
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic              k,
  input wire logic              k_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              rd_sel_n,
  input wire logic              wr_sel_n,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              read_valid_flag,
  input wire logic              echo_clock,
  input wire logic              echo_clock_n,
  input wire logic              latency_select_pin
);
  logic k_d_q;
  logic slot_q;
  logic rd_cap;
  logic rd_skip;

  // Slot tracker, first k rise after reset is a read slot
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      k_d_q  <= 1'b0;
      slot_q <= 1'b0;
    end else begin
      k_d_q  <= k;
      slot_q <= slot_q ^ (k & ~k_d_q);
    end
  end

  // Read slot edges, selected or not
  assign rd_cap  = k & ~k_d_q & ~slot_q & ~rd_sel_n;
  assign rd_skip = k & ~k_d_q & ~slot_q & rd_sel_n;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_k_pair; k_n == !k; endproperty
  a_k_pair: assert property (p_k_pair)
    else $error("link clock pair not complementary");
  property p_k_shape; $rose(k) |-> k[*4] ##1 (!k)[*4] ##1 k; endproperty
  a_k_shape: assert property (p_k_shape)
    else $error("link clock period wrong");
  property p_link_stable; $changed({addr, wr_data, rd_sel_n, wr_sel_n}) |-> $stable(k);
  endproperty
  a_link_stable: assert property (p_link_stable)
    else $error("link inputs change at a clock rise");
  property p_echo; $rose(k) |-> ##[3:7] $rose(echo_clock); endproperty
  a_echo: assert property (p_echo)
    else $error("echo clock missing after k rise");
  property p_echo_n; $rose(k_n) |-> ##[3:7] $rose(echo_clock_n); endproperty
  a_echo_n: assert property (p_echo_n)
    else $error("inverse echo clock missing");
  property p_lat_hi; rd_cap && latency_select_pin |-> ##28 read_valid_flag; endproperty
  a_lat_hi: assert property (p_lat_hi)
    else $error("long latency read data absent");
  property p_lat_lo; rd_cap && !latency_select_pin |-> ##16 read_valid_flag; endproperty
  a_lat_lo: assert property (p_lat_lo)
    else $error("short latency read data absent");
  property p_desel; rd_skip && latency_select_pin |-> ##28 !read_valid_flag; endproperty
  a_desel: assert property (p_desel)
    else $error("read burst without select");
  property p_burst; $rose(read_valid_flag) |-> read_valid_flag[*8] ##1 read_valid_flag[*8];
  endproperty
  a_burst: assert property (p_burst)
    else $error("read burst shorter than four words");
  property p_data_flag; $changed(rd_data) |-> read_valid_flag; endproperty
  a_data_flag: assert property (p_data_flag)
    else $error("read data moved outside valid window");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import bspi_pkg::*;
  localparam int DW = 18;
  localparam int AW = 6;
  logic            core_clk;
  logic            arst_n;
  logic            latency_select;
  logic            wr_valid;
  logic            rd_valid;
  logic            rsp_ready;
  logic            stall;
  logic            wr_ready;
  logic            rd_ready;
  logic            rsp_valid;
  logic [AW-1:0]   wr_addr;
  logic [AW-1:0]   rd_addr;
  logic [4*DW-1:0] wr_data;
  logic [DW-1:0]   rsp_data;
  int              miscompares;
  int              checks;
  int              seed = 32'h65F75708;
  int              n;
  logic [4*DW-1:0] mem [int];
  logic [DW-1:0]   exp_q [$];
  logic [AW-1:0]   addrs [$];
  logic [AW-1:0]   a;
  logic [4*DW-1:0] d;

  bspi_link_if #(.DATA_W(DW), .ADDR_W(AW)) bspi_link_if_inst ();
  bspi_dev #(.DATA_W(DW), .ADDR_W(AW)) bspi_dev_inst (
    .core_clk(core_clk), .arst_n(arst_n), .link(bspi_link_if_inst));
  bspi_ctl #(.DATA_W(DW), .ADDR_W(AW)) bspi_ctl_inst (
    .core_clk(core_clk), .arst_n(arst_n), .link(bspi_link_if_inst),
    .latency_select(latency_select), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data));
  bspi_link_monitor #(.DATA_W(DW), .ADDR_W(AW)) bspi_link_monitor_inst (
    .core_clk(core_clk), .arst_n(arst_n), .k(bspi_link_if_inst.k),
    .k_n(bspi_link_if_inst.k_n), .addr(bspi_link_if_inst.addr),
    .rd_sel_n(bspi_link_if_inst.rd_sel_n), .wr_sel_n(bspi_link_if_inst.wr_sel_n),
    .wr_data(bspi_link_if_inst.wr_data), .rd_data(bspi_link_if_inst.rd_data),
    .read_valid_flag(bspi_link_if_inst.read_valid_flag),
    .echo_clock(bspi_link_if_inst.echo_clock), .echo_clock_n(bspi_link_if_inst.echo_clock_n),
    .latency_select_pin(bspi_link_if_inst.latency_select_pin));

  // ----------------------------------------------------------------
  // Clock, checking and closing
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog, generous against roughly a thousand expected cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Request tasks; the wire is checked one cycle after the take
  // ----------------------------------------------------------------
  task automatic do_wr(input logic [AW-1:0] wa, input logic [4*DW-1:0] wd);
    int c;
    c = 0;
    @(posedge core_clk);
    wr_valid <= 1'b1;
    wr_addr  <= wa;
    wr_data  <= wd;
    do begin
      @(posedge core_clk);
      c++;
    end while (wr_ready !== 1'b1 && c < 64);
    wr_valid <= 1'b0;
    mem[wa] = wd;
    @(posedge core_clk);
    #1;
    check(DW'(c < 64), 1);
    check(DW'(bspi_link_if_inst.wr_sel_n), 0);
    check(DW'(bspi_link_if_inst.addr), DW'(wa));
    check(bspi_link_if_inst.wr_data, wd[DW-1:0]);
  endtask

  task automatic do_rd(input logic [AW-1:0] ra);
    int c;
    c = 0;
    @(posedge core_clk);
    rd_valid <= 1'b1;
    rd_addr  <= ra;
    do begin
      @(posedge core_clk);
      c++;
    end while (rd_ready !== 1'b1 && c < 400);
    rd_valid <= 1'b0;
    for (int i = 0; i < 4; i++) exp_q.push_back(mem[ra][i*DW +: DW]);
    @(posedge core_clk);
    #1;
    check(DW'(c < 400), 1);
    check(DW'(bspi_link_if_inst.rd_sel_n), 0);
    check(DW'(bspi_link_if_inst.addr), DW'(ra));
  endtask

  // Response sink with random stalls; words must come back in order
  always @(posedge core_clk) begin
    rsp_ready <= stall ? 1'b0 : 1'($random(seed));
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() == 0) check(DW'(1), 0);
      else check(rsp_data, exp_q.pop_front());
    end
  end

  task automatic drain();
    stall <= 1'b0;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge core_clk);
    check(DW'(exp_q.size()), 0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    latency_select = 1'b1;
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    stall = 1'b0;
    wr_addr = '0;
    rd_addr = '0;
    wr_data = '0;
    miscompares = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    // Address extremes, random places, and a rewrite of address zero
    for (int i = 0; i < 9; i++) begin
      a = (i == 0 || i == 8) ? '0 : (i == 1) ? '1 : AW'($random(seed));
      do_wr(a, (4*DW)'({$random(seed), $random(seed), $random(seed)}));
      addrs.push_back(a);
    end
    // Both latencies, reads running beside writes to other places
    for (int l = 1; l >= 0; l--) begin
      latency_select <= l[0];
      repeat (40) @(posedge core_clk);
      foreach (addrs[i]) begin
        a = addrs[(i + 3) % addrs.size()];
        d = (a == addrs[i]) ? mem[a] : (4*DW)'({$random(seed), $random(seed), $random(seed)});
        fork
          do_rd(addrs[i]);
          do_wr(a, d);
        join
      end
      drain();
    end
    // Stalled sink: reads stop once the buffer is committed
    stall <= 1'b1;
    n = 0;
    rd_addr <= addrs[2];
    rd_valid <= 1'b1;
    repeat (400) begin
      @(posedge core_clk);
      if (rd_ready === 1'b1) begin
        n++;
        for (int i = 0; i < 4; i++) exp_q.push_back(mem[addrs[2]][i*DW +: DW]);
      end
    end
    rd_valid <= 1'b0;
    check(DW'(n), DW'(RSP_FIFO_DEPTH / BURST_LEN));
    drain();
    test_done();
  end
endmodule
